// file: include/tss_map.svh
// Contract
// RULE1 - Pointer 0-3 selects temp, config, low, high
// RULE2 - Bus address set by three pins, fixed variant 000
// RULE3 - Host writes high via 03h, low via 02h
// RULE4 - Alarm activates above high limit, after fault count
// RULE5 - Active alarm releases below low limit
// RULE6 - Sense bit one active high, zero active low
// RULE7 - Shutdown bit one standby, zero continuous conversion
// RULE8 - Shutdown stops conversions, comparator output holds
// RULE9 - Mode bit zero comparator, one interrupt
// RULE10 - Fault codes need 1, 2, 4, 6 conversions
// RULE11 - Resolution 9 to 12 bits, 0.15s to 1.2s
// RULE12 - Config byte layout, bit7 always zero
// RULE13 - Value 65 gives shutdown, high sense, 12-bit
// RULE14 - In-limit result clears consecutive fault counter
// RULE15 - Unused result bits below resolution read zero
`ifndef TSS_MAP_SVH
`define TSS_MAP_SVH

// ---------------------------------------------------------------
// Pointer codes
// ---------------------------------------------------------------
`define TSS_PTR_TEMP    2'h0
`define TSS_PTR_CFG     2'h1
`define TSS_PTR_LOW     2'h2
`define TSS_PTR_HIGH    2'h3

// ---------------------------------------------------------------
// Reset values and addressing
// ---------------------------------------------------------------
`define TSS_CFG_RST     8'h00
`define TSS_LOW_RST     16'h4b00
`define TSS_HIGH_RST    16'h5000
`define TSS_TEMP_RST    16'h0000
// Upper four address bits; value is arbitrary
`define TSS_ADDR_BASE   4'h9

// ---------------------------------------------------------------
// Fault count needs and result masks
// ---------------------------------------------------------------
`define TSS_NEED_0      3'h1
`define TSS_NEED_1      3'h2
`define TSS_NEED_2      3'h4
`define TSS_NEED_3      3'h6
`define TSS_MASK_9      16'hff80
`define TSS_MASK_10     16'hffc0
`define TSS_MASK_11     16'hffe0
`define TSS_MASK_12     16'hfff0
`define TSS_BYTE_BITS   4'h8

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define TSS_CLK_HZ      125000000
`define TSS_T9_MS       150
`define TSS_T10_MS      300
`define TSS_T11_MS      600
`define TSS_T12_MS      1200

`endif

// file: include/tss_pkg.sv
package tss_pkg;

  // ---------------------------------------------------------------
  // Configuration byte, bit7 first
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       zero_bit;
    logic [1:0] resolution;
    logic [1:0] fault_count;
    logic       output_sense_sel;
    logic       thermostat_mode_sel;
    logic       shutdown_bit;
  } tss_cfg_s;

  // ---------------------------------------------------------------
  // Register write request from the bus engine
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        en;
    logic [1:0]  ptr;
    logic [15:0] data;
  } tss_wr_s;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_ACK_A,
    BUS_WR,
    BUS_ACK_W,
    BUS_RD,
    BUS_RACK
  } tss_bus_e;

endpackage

// file: rtl/tss_link.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Serial capture on the link clock
// ---------------------------------------------------------------
// Data is set up to the rising clock edge by the host, so it is
// synchronous here. The byte stays still from the eighth rising
// edge until the next one; the system side reads it after the falling edge between them.
module tss_link (
  input  wire logic       scl_clk,
  input  wire logic       sda_i,
  output logic [7:0]      rx_byte_q
);

  always_ff @(posedge scl_clk) begin
    rx_byte_q <= {rx_byte_q[6:0], sda_i};
  end

endmodule

// file: rtl/tss_regs.sv
`timescale 1ns/10ps
`include "tss_map.svh"
module tss_regs #(
  parameter logic       FIXED_ADDR = 1'b0,
  parameter int         CONV9_CYC  = `TSS_T9_MS * (`TSS_CLK_HZ / 1000),
  parameter int         CONV10_CYC = `TSS_T10_MS * (`TSS_CLK_HZ / 1000),
  parameter int         CONV11_CYC = `TSS_T11_MS * (`TSS_CLK_HZ / 1000),
  parameter int         CONV12_CYC = `TSS_T12_MS * (`TSS_CLK_HZ / 1000)
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        scl_clk,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        addr_pin_2,
  input  wire logic        addr_pin_1,
  input  wire logic        addr_pin_0,
  input  wire logic [11:0] adc_temp,
  output logic             alarm_out
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic tss_gt(input logic [15:0] a,
                                  input logic [15:0] b);
    tss_gt = $signed(a) > $signed(b);
  endfunction

  function automatic logic [2:0] tss_need(input logic [1:0] code);
    case (code)
      2'h0:    tss_need = `TSS_NEED_0;
      2'h1:    tss_need = `TSS_NEED_1;
      2'h2:    tss_need = `TSS_NEED_2;
      default: tss_need = `TSS_NEED_3;
    endcase
  endfunction

  function automatic logic [15:0] tss_mask(input logic [1:0] res);
    case (res)
      2'h0:    tss_mask = `TSS_MASK_9;
      2'h1:    tss_mask = `TSS_MASK_10;
      2'h2:    tss_mask = `TSS_MASK_11;
      default: tss_mask = `TSS_MASK_12;
    endcase
  endfunction

  function automatic logic [27:0] tss_len(input logic [1:0] res);
    case (res)
      2'h0:    tss_len = 28'(CONV9_CYC);
      2'h1:    tss_len = 28'(CONV10_CYC);
      2'h2:    tss_len = 28'(CONV11_CYC);
      default: tss_len = 28'(CONV12_CYC);
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0]        pin_m_q;
  logic [4:0]        pin_q;
  logic              scl_p_q;
  logic              sda_p_q;
  logic [11:0]       adc_m_q;
  logic [11:0]       adc_q;
  logic [7:0]        rx_byte;

  always_ff @(posedge clk_sys) begin
    pin_m_q <= {scl_clk, sda_i, addr_pin_2, addr_pin_1, addr_pin_0};
    pin_q   <= pin_m_q;
    scl_p_q <= pin_q[4];
    sda_p_q <= pin_q[3];
    adc_m_q <= adc_temp;
    adc_q   <= adc_m_q;
  end

  tss_link u_link (
    .scl_clk   (scl_clk),
    .sda_i     (sda_i),
    .rx_byte_q (rx_byte)
  );

  logic       scl_s;
  logic       sda_s;
  logic       bus_start;
  logic       bus_stop;
  logic       scl_rise;
  logic       scl_fall;
  logic [6:0] dev_addr;

  assign scl_s     = pin_q[4];
  assign sda_s     = pin_q[3];
  assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign dev_addr  = {`TSS_ADDR_BASE,
                      FIXED_ADDR ? 3'h0 : pin_q[2:0]}; // [RULE2]

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  tss_pkg::tss_cfg_s cfg_q;
  tss_pkg::tss_wr_s  wr_q;
  logic [15:0]       low_q;
  logic [15:0]       high_q;
  logic [15:0]       temp_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cfg_q  <= `TSS_CFG_RST;
      low_q  <= `TSS_LOW_RST;
      high_q <= `TSS_HIGH_RST;
    end else if (wr_q.en) begin
      case (wr_q.ptr)
        `TSS_PTR_CFG: begin
          cfg_q          <= wr_q.data[7:0]; // [RULE12] [RULE13]
          cfg_q.zero_bit <= 1'b0;
        end
        `TSS_PTR_LOW:  low_q  <= wr_q.data; // [RULE3]
        `TSS_PTR_HIGH: high_q <= wr_q.data; // [RULE3]
        default: ;
      endcase
    end
  end

  function automatic logic [7:0] rd_byte(input logic [1:0] ptr,
                                         input logic       lsb);
    case (ptr)
      `TSS_PTR_TEMP: rd_byte = lsb ? temp_q[7:0] : temp_q[15:8];
      `TSS_PTR_CFG:  rd_byte = cfg_q;
      `TSS_PTR_LOW:  rd_byte = lsb ? low_q[7:0] : low_q[15:8];
      default:       rd_byte = lsb ? high_q[7:0] : high_q[15:8];
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Bus engine
  // ---------------------------------------------------------------
  // Acks and read data change only after a seen falling clock,
  // a few system cycles late, well inside the low phase.
  tss_pkg::tss_bus_e state_q;
  logic [3:0]        bit_q;
  logic [1:0]        ptr_q;
  logic              first_q;
  logic              lsb_q;
  logic              rw_q;
  logic              nack_q;
  logic [7:0]        msb_q;
  logic [7:0]        tx_q;
  logic              rd_clr_q;
  logic [7:0]        nxt;

  assign nxt = rd_byte(ptr_q, lsb_q);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q  <= tss_pkg::BUS_IDLE;
      bit_q    <= 4'h0;
      ptr_q    <= `TSS_PTR_TEMP; // [RULE1]
      first_q  <= 1'b0;
      lsb_q    <= 1'b0;
      rw_q     <= 1'b0;
      nack_q   <= 1'b0;
      msb_q    <= 8'h00;
      tx_q     <= 8'h00;
      sda_oe   <= 1'b0;
      wr_q     <= '0;
      rd_clr_q <= 1'b0;
    end else begin
      wr_q.en  <= 1'b0;
      rd_clr_q <= 1'b0;
      if (bus_start) begin
        state_q <= tss_pkg::BUS_ADDR;
        bit_q   <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (bus_stop) begin
        state_q <= tss_pkg::BUS_IDLE;
        sda_oe  <= 1'b0;
      end else begin
        case (state_q)
          tss_pkg::BUS_ADDR: begin
            if (scl_rise)
              bit_q <= bit_q + 4'h1;
            if (scl_fall && bit_q == `TSS_BYTE_BITS) begin
              bit_q <= 4'h0;
              if (rx_byte[7:1] == dev_addr) begin // [RULE2]
                sda_oe  <= 1'b1;
                rw_q    <= rx_byte[0];
                first_q <= 1'b1;
                state_q <= tss_pkg::BUS_ACK_A;
              end else begin
                state_q <= tss_pkg::BUS_IDLE;
              end
            end
          end
          tss_pkg::BUS_ACK_A: begin
            if (scl_fall) begin
              if (rw_q) begin
                tx_q     <= nxt;
                sda_oe   <= ~nxt[7];
                lsb_q    <= ~lsb_q;
                rd_clr_q <= 1'b1;
                state_q  <= tss_pkg::BUS_RD;
              end else begin
                sda_oe  <= 1'b0;
                state_q <= tss_pkg::BUS_WR;
              end
            end
          end
          tss_pkg::BUS_WR: begin
            if (scl_rise)
              bit_q <= bit_q + 4'h1;
            if (scl_fall && bit_q == `TSS_BYTE_BITS) begin
              bit_q   <= 4'h0;
              sda_oe  <= 1'b1;
              state_q <= tss_pkg::BUS_ACK_W;
              if (first_q) begin
                ptr_q   <= rx_byte[1:0]; // [RULE1]
                first_q <= 1'b0;
                lsb_q   <= 1'b0;
              end else if (ptr_q == `TSS_PTR_CFG) begin
                wr_q <= '{en: 1'b1, ptr: ptr_q, data: {8'h00, rx_byte}};
              end else if (!lsb_q) begin
                msb_q <= rx_byte;
                lsb_q <= 1'b1;
              end else begin
                wr_q  <= '{en: 1'b1, ptr: ptr_q, data: {msb_q, rx_byte}};
                lsb_q <= 1'b0;
              end
            end
          end
          tss_pkg::BUS_ACK_W: begin
            if (scl_fall) begin
              sda_oe  <= 1'b0;
              state_q <= tss_pkg::BUS_WR;
            end
          end
          tss_pkg::BUS_RD: begin
            if (scl_rise)
              bit_q <= bit_q + 4'h1;
            if (scl_fall) begin
              if (bit_q == `TSS_BYTE_BITS) begin
                bit_q   <= 4'h0;
                sda_oe  <= 1'b0;
                state_q <= tss_pkg::BUS_RACK;
              end else begin
                tx_q   <= {tx_q[6:0], 1'b0};
                sda_oe <= ~tx_q[6];
              end
            end
          end
          tss_pkg::BUS_RACK: begin
            if (scl_rise)
              nack_q <= sda_s;
            if (scl_fall) begin
              if (nack_q) begin
                state_q <= tss_pkg::BUS_IDLE;
              end else begin
                tx_q    <= nxt;
                sda_oe  <= ~nxt[7];
                lsb_q   <= ~lsb_q;
                state_q <= tss_pkg::BUS_RD;
              end
            end
          end
          default: state_q <= tss_pkg::BUS_IDLE;
        endcase
      end
    end
  end

  // Open drain: the pin is only ever pulled low
  always_ff @(posedge clk_sys) begin
    sda_o <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Conversion timing
  // ---------------------------------------------------------------
  logic [27:0] conv_cnt_q;
  logic        conv_end;
  logic [15:0] conv_val;

  assign conv_end = !cfg_q.shutdown_bit &&
                    conv_cnt_q >= tss_len(cfg_q.resolution) - 28'h1;
  assign conv_val = {adc_q, 4'h0} & tss_mask(cfg_q.resolution); // [RULE15]

  always_ff @(posedge clk_sys) begin
    if (!rst_b || cfg_q.shutdown_bit || conv_end)
      conv_cnt_q <= 28'h0; // [RULE7] [RULE8] [RULE11]
    else
      conv_cnt_q <= conv_cnt_q + 28'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b)
      temp_q <= `TSS_TEMP_RST;
    else if (conv_end)
      temp_q <= conv_val;
  end

  // ---------------------------------------------------------------
  // Thermostat
  // ---------------------------------------------------------------
  // Release also needs the configured run of results, as the
  // counter watches whichever limit is being waited on.
  logic       os_act_q;
  logic       dir_q;
  logic [2:0] flt_q;
  logic       hot;
  logic       cold;
  logic       excur;

  assign hot   = tss_gt(conv_val, high_q);
  assign cold  = tss_gt(low_q, conv_val);
  assign excur = (cfg_q.thermostat_mode_sel ? dir_q : os_act_q) ? cold
                                                                : hot;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      os_act_q <= 1'b0;
      dir_q    <= 1'b0;
      flt_q    <= 3'h0;
    end else begin
      if (rd_clr_q && cfg_q.thermostat_mode_sel)
        os_act_q <= 1'b0; // [RULE9]
      if (conv_end) begin
        if (!excur) begin
          flt_q <= 3'h0; // [RULE14]
        end else if (flt_q + 3'h1 >= tss_need(cfg_q.fault_count)) begin
          flt_q <= 3'h0; // [RULE10]
          if (cfg_q.thermostat_mode_sel) begin
            os_act_q <= 1'b1; // [RULE9]
            dir_q    <= ~dir_q;
          end else begin
            os_act_q <= ~os_act_q; // [RULE4] [RULE5]
          end
        end else begin
          flt_q <= flt_q + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b)
      alarm_out <= 1'b1;
    else
      alarm_out <= ~(os_act_q ^ cfg_q.output_sense_sel); // [RULE6]
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  a_ptr_default: assert property ($rose(rst_b) |-> ptr_q == `TSS_PTR_TEMP) // [RULE1]
    else $error("pointer not temperature after reset");
  a_addr_reject: assert property (state_q == tss_pkg::BUS_ADDR && !bus_start
      && !bus_stop && scl_fall && bit_q == `TSS_BYTE_BITS
      && rx_byte[7:1] != dev_addr |=> state_q == tss_pkg::BUS_IDLE && !sda_oe) // [RULE2]
    else $error("foreign address acknowledged");
  // The pin lags the alarm state by one register stage
  a_sense_out: assert property (alarm_out == ($past(cfg_q.output_sense_sel)
      ? $past(os_act_q) : !$past(os_act_q))) // [RULE6]
    else $error("alarm pin sense wrong");
  a_sd_noconv: assert property (cfg_q.shutdown_bit |-> !conv_end ##1
      conv_cnt_q == 28'h0) // [RULE7]
    else $error("conversion during shutdown");
  a_sd_hold: assert property (cfg_q.shutdown_bit && $past(cfg_q.shutdown_bit)
      && !cfg_q.thermostat_mode_sel |-> $stable(os_act_q)) // [RULE8]
    else $error("alarm moved in shutdown");
  a_fault_need: assert property ($rose(os_act_q) && !cfg_q.thermostat_mode_sel
      && $stable(cfg_q.fault_count)
      |-> $past(flt_q) == tss_need(cfg_q.fault_count) - 3'h1) // [RULE4] [RULE10]
    else $error("alarm before fault count reached");
  a_low_release: assert property (conv_end && os_act_q && cold
      && !cfg_q.thermostat_mode_sel && cfg_q.fault_count == 2'h0
      |=> !os_act_q) // [RULE5]
    else $error("alarm not released below low limit");
  a_fault_clear: assert property (conv_end && !excur |=> flt_q == 3'h0) // [RULE14]
    else $error("fault run not cleared");
  a_res_mask: assert property (conv_end |=> (temp_q
      & ~tss_mask($past(cfg_q.resolution))) == 16'h0000) // [RULE15]
    else $error("unused result bits not zero");
  a_conv_len: assert property (conv_cnt_q < tss_len(cfg_q.resolution)
      || $changed(cfg_q.resolution)) // [RULE11]
    else $error("conversion overran its time");
  a_cfg_zero: assert property (!cfg_q.zero_bit) // [RULE12] [RULE13]
    else $error("config bit7 set");
  a_int_clear: assert property (rd_clr_q && cfg_q.thermostat_mode_sel
      && !conv_end |=> !os_act_q) // [RULE9]
    else $error("interrupt output not cleared by read");

endmodule

// file: tb/tss_host.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Two-wire host model
// ---------------------------------------------------------------
// The clock stands high between frames and data goes back to the
// pull-up whenever the host lets go. Phases of 80 ns give a 160 ns
// link clock, unrelated in phase to the system clock.
module tss_host (
  output logic      scl_clk,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl_clk = 1'b1;
    sda_low = 1'b0;
  end

  // Data only moves while the clock is low, away from its edges
  task automatic bit_io(input logic b, output logic r);
    #20 sda_low = !b;
    #60 scl_clk = 1'b1;
    #40 r = sda;
    #40 scl_clk = 1'b0;
  endtask

  task automatic start();
    #20 sda_low = 1'b0;
    #60 scl_clk = 1'b1;
    #40 sda_low = 1'b1;
    #40 scl_clk = 1'b0;
  endtask

  task automatic stop();
    #20 sda_low = 1'b1;
    #60 scl_clk = 1'b1;
    #40 sda_low = 1'b0;
    #80;
  endtask

  // Eight bits most significant first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic b9,
                      output logic [7:0] q, output logic r9);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(b9, r9);
  endtask
endmodule

// file: tb/tss_regs_bench.sv
`timescale 1ns/10ps
`include "tss_map.svh"
module tss_regs_bench;
  logic        clk_sys;
  logic        rst_b;
  logic        scl_clk;
  logic        sda_low;
  logic        sda_o;
  logic        sda_oe;
  logic        fx_o;
  logic        fx_oe;
  logic        alarm_out;
  logic [2:0]  pins;
  logic [11:0] adc_temp;
  logic [15:0] v;
  int          err_total;
  int          tests_run;
  int          need [4] = '{1, 2, 4, 6};
  logic [15:0] mask [4] = '{16'h1980, 16'h19c0, 16'h19e0, 16'h19f0};
  // Open-drain wire with pull-up shared by all three parties
  wire sda = (sda_low || (sda_oe && !sda_o) || (fx_oe && !fx_o)) ?
             1'b0 : 1'b1;

  // ---------------------------------------------------------------
  // Parties on the bus
  // ---------------------------------------------------------------
  tss_host i_tss_host (.scl_clk(scl_clk), .sda_low(sda_low), .sda(sda));

  tss_regs #(.CONV9_CYC(50), .CONV10_CYC(100), .CONV11_CYC(150),
             .CONV12_CYC(200)) i_tss_regs (
    .clk_sys(clk_sys), .rst_b(rst_b), .scl_clk(scl_clk), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .addr_pin_2(pins[2]),
    .addr_pin_1(pins[1]), .addr_pin_0(pins[0]), .adc_temp(adc_temp),
    .alarm_out(alarm_out));

  // Fixed-address variant sharing the wire; its pins must not matter
  tss_regs #(.FIXED_ADDR(1'b1)) i_tss_regs_fixed (
    .clk_sys(clk_sys), .rst_b(rst_b), .scl_clk(scl_clk), .sda_i(sda),
    .sda_o(fx_o), .sda_oe(fx_oe), .addr_pin_2(~pins[2]),
    .addr_pin_1(~pins[1]), .addr_pin_0(~pins[0]), .adc_temp(adc_temp),
    .alarm_out());

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic send(input logic [7:0] d);
    logic [7:0] q;
    logic       r;
    i_tss_host.xfer(d, 1'b1, q, r);
    check({15'h0, !r}, 16'h1);
  endtask

  task automatic reg_wr(input logic [1:0] p, input logic [15:0] d,
                        input int n);
    i_tss_host.start();
    send({`TSS_ADDR_BASE, pins, 1'b0});
    send({6'h0, p});
    if (n == 2) send(d[15:8]);
    if (n > 0) send(d[7:0]);
    i_tss_host.stop();
  endtask

  task automatic reg_rd(input logic setp, input logic [1:0] p,
                        input int n, output logic [15:0] d);
    logic [7:0] q;
    logic       r;
    d = 16'h0;
    if (setp) begin
      i_tss_host.start();
      send({`TSS_ADDR_BASE, pins, 1'b0});
      send({6'h0, p});
    end
    i_tss_host.start();
    send({`TSS_ADDR_BASE, pins, 1'b1});
    for (int i = n; i > 0; i--) begin
      i_tss_host.xfer(8'hff, i == 1, q, r);
      d = {d[7:0], q};
    end
    i_tss_host.stop();
  endtask

  task automatic probe(input logic [2:0] a, input logic exp);
    logic [7:0] q;
    logic       r;
    i_tss_host.start();
    i_tss_host.xfer({`TSS_ADDR_BASE, a, 1'b0}, 1'b1, q, r);
    i_tss_host.stop();
    check({15'h0, !r}, {15'h0, exp});
  endtask

  task automatic set_adc(input logic [11:0] t);
    @(posedge clk_sys);
    #1 adc_temp = t;
  endtask

  // Cycles from the input change until the alarm reaches lvl
  task automatic alarm_wait(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (alarm_out !== lvl) begin
      @(posedge clk_sys);
      #1 n++;
      if (n > hi) begin
        check({15'h0, alarm_out}, {15'h0, lvl});
        final_report();
      end
    end
    check({15'h0, n >= lo}, 16'h1);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    err_total = 0;
    tests_run = 0;
    rst_b = 1'b0;
    pins = 3'h2;
    adc_temp = 12'h19f;
    repeat (10) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    repeat (60) @(posedge clk_sys);
    #1 check({15'h0, alarm_out}, 16'h1);
    reg_rd(1'b0, 2'h0, 2, v);
    check(v, 16'h1980);
    reg_rd(1'b1, 2'h1, 1, v);
    check(v, 16'h0000);
    reg_rd(1'b1, 2'h2, 2, v);
    check(v, `TSS_LOW_RST);
    reg_rd(1'b1, 2'h3, 2, v);
    check(v, `TSS_HIGH_RST);
    reg_wr(2'h0, 16'h1234, 2);
    reg_rd(1'b1, 2'h0, 2, v);
    check(v, 16'h1980);
    for (int r = 0; r < 4; r++) begin
      reg_wr(2'h1, {9'h0, r[1:0], 5'h0}, 1);
      repeat (420) @(posedge clk_sys);
      reg_rd(1'b1, 2'h0, 2, v);
      check(v, mask[r]);
      check({15'h0, alarm_out}, 16'h1);
    end
    reg_wr(2'h1, 16'h00fc, 1);
    reg_rd(1'b1, 2'h1, 1, v);
    check(v, 16'h007c);
    set_adc(12'h190);
    reg_wr(2'h3, 16'h1a00, 2);
    reg_wr(2'h2, 16'h1900, 2);
    reg_rd(1'b1, 2'h3, 2, v);
    check(v, 16'h1a00);
    for (int f = 0; f < 4; f++) begin
      reg_wr(2'h1, {11'h0, f[1:0], 3'h4}, 1);
      check({15'h0, alarm_out}, 16'h0);
      set_adc(12'h1b0);
      alarm_wait(1'b1, need[f] * 50 - 49, need[f] * 50 + 8);
      set_adc(12'h170);
      alarm_wait(1'b0, need[f] * 50 - 49, need[f] * 50 + 8);
      set_adc(12'h190);
    end
    set_adc(12'h1b0);
    repeat (160) @(posedge clk_sys);
    set_adc(12'h190);
    repeat (60) @(posedge clk_sys);
    #1 check({15'h0, alarm_out}, 16'h0);
    set_adc(12'h1b0);
    alarm_wait(1'b1, 251, 308);
    reg_wr(2'h1, 16'h0065, 1);
    reg_rd(1'b1, 2'h1, 1, v);
    check(v, 16'h0065);
    set_adc(12'h170);
    repeat (700) @(posedge clk_sys);
    #1 check({15'h0, alarm_out}, 16'h1);
    reg_rd(1'b1, 2'h0, 2, v);
    check(v, 16'h1b00);
    reg_wr(2'h1, 16'h0064, 1);
    alarm_wait(1'b0, 1, 220);
    reg_rd(1'b1, 2'h0, 2, v);
    check(v, 16'h1700);
    set_adc(12'h190);
    reg_wr(2'h1, 16'h0006, 1);
    set_adc(12'h1b0);
    alarm_wait(1'b1, 1, 60);
    set_adc(12'h190);
    repeat (120) @(posedge clk_sys);
    #1 check({15'h0, alarm_out}, 16'h1);
    reg_rd(1'b1, 2'h1, 1, v);
    check({15'h0, alarm_out}, 16'h0);
    set_adc(12'h170);
    alarm_wait(1'b1, 1, 60);
    reg_rd(1'b0, 2'h1, 1, v);
    check({15'h0, alarm_out}, 16'h0);
    for (int p = 0; p < 8; p++) begin
      @(posedge clk_sys);
      #1 pins = p[2:0];
      repeat (6) @(posedge clk_sys);
      probe(p[2:0], 1'b1);
      probe(p[2:0] + 3'h1, p == 7);
    end
    final_report();
  end
endmodule
